// ### verilog/scar_regs.sv
// Status, global command and x-axis alarm words behind the serial port.
// Assumes the alarm, flash and capture engines share core_clk.
//
// How it works
// - Set status bit 14 on a system alarm threshold crossing.
// - Status bits 13..8 carry spectral alarm 2 then 1 for z, y, x.
// - Status bit 7 is 0 while busy, 1 when data ready.
// - Status bit 6 shows the flash checksum result, 1 is error.
// - Command bit 2 runs self test; failure sets status bit 5.
// - Frame 0x00E8 sets status bit 4; a good recording clears it.
// - Status bit 3 flags a clock count not a multiple of 16.
// - Status bit 1 flags supply high, bit 0 supply low.
// - Host writes one to start; device clears the bit when done.
// - Command bit 0 autonulls, bit 15 clears the autonull correction.
// - Command bit 14 loads band settings chosen by the band pointer.
// - Bit 12 saves bands to flash, 9 erases them, 13 retrieves records.
// - Command bit 11 starts recording when idle, stops it otherwise.
// - Command bit 10 resets the buffer position pointer to zero.
// - Bit 3 restores factory settings, 8 clears records, 7 resets.
// - Bit 6 saves user registers; status bit 2 flags update failure.
// - Command bit 5 runs the flash checksum test into bit 6.
// - Command bit 4 clears the status word once.
// - Bit 1 sleeps; chip select toggle or capture timer wakes.
// - X alarm word bits 15..4 hold band 6..1 alarm 2 and 1 flags.
// - X alarm bits 2..0 give the worst band, bit 3 unused.
// - With latching enabled, error flags hold until status clear.
// - Reading status clears spectral bits unless disabled.
`default_nettype none

module scar_regs
    import scar_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Serial port pins
    input wire scar_spi_in_t spi_in,
    output logic miso,
    output logic miso_oe,
    // Engine inputs
    input wire scar_events_t events,
    input wire scar_cfg_t cfg,
    input wire scar_xalm_t xalm,
    input wire logic timer_wake,
    input wire logic [15:0] cmd_done,
    // Engine outputs
    output logic [15:0] cmd_go,
    output logic sensor_sleep,
    output logic recording
);

    // ========================================
    // Address decode
    function automatic logic addr_is(input logic [6:0] a,
                                     input logic [6:0] t);
        addr_is = (a[6:1] == t[6:1]);
    endfunction

    // ========================================
    // Pin synchronisers
    logic [2:0] sclk_s_r;
    logic [2:0] cs_s_r;
    logic [1:0] mosi_s_r;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sclk_s_r <= 3'h7;
            cs_s_r <= 3'h7;
            mosi_s_r <= 2'h0;
        end else begin
            sclk_s_r <= {sclk_s_r[1:0], spi_in.sclk};
            cs_s_r <= {cs_s_r[1:0], spi_in.cs_n};
            mosi_s_r <= {mosi_s_r[0], spi_in.mosi};
        end
    end

    assign sclk_rise = sclk_s_r[1] & ~sclk_s_r[2];
    assign sclk_fall = ~sclk_s_r[1] & sclk_s_r[2];
    assign cs_fall = ~cs_s_r[1] & cs_s_r[2];
    assign cs_rise = cs_s_r[1] & ~cs_s_r[2];

    // ========================================
    // Receive side
    logic [14:0] rx_r;
    logic [3:0] cnt_r;
    logic frame_done_r;
    logic [15:0] frame_r;
    logic frame_err_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_r <= 15'h0000;
            cnt_r <= CNT_ZERO;
            frame_done_r <= 1'b0;
            frame_r <= WORD_ZERO;
            frame_err_r <= 1'b0;
        end else begin
            frame_done_r <= 1'b0;
            frame_err_r <= cs_rise && (cnt_r != CNT_ZERO);
            if (cs_fall) begin
                cnt_r <= CNT_ZERO;
            end else if (sclk_rise && !cs_s_r[1]) begin
                rx_r <= {rx_r[13:0], mosi_s_r[1]};
                cnt_r <= cnt_r + CNT_STEP;
                if (cnt_r == CNT_LAST) begin
                    frame_done_r <= 1'b1;
                    frame_r <= {rx_r, mosi_s_r[1]};
                end
            end
        end
    end

    logic wr_frame, rd_frame, esc_frame;
    logic [6:0] frame_addr;
    assign frame_addr = frame_r[ADDR_HI:ADDR_LO];
    assign wr_frame = frame_done_r && frame_r[FRAME_RW];
    assign rd_frame = frame_done_r && !frame_r[FRAME_RW];
    assign esc_frame = frame_done_r && (frame_r == ESCAPE_FRAME);

    // ========================================
    // Read path
    logic [6:0] rd_addr_r;
    logic [15:0] rd_word;
    logic [15:0] tx_r;
    logic oe_r;
    logic [15:0] diag_r;
    logic [15:0] almx_r;
    logic stat_read;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_addr_r <= 7'h00;
        end else if (rd_frame) begin
            rd_addr_r <= frame_addr;
        end
    end

    always_comb begin
        rd_word = WORD_ZERO;
        if (addr_is(rd_addr_r, ADDR_DIAG)) begin
            rd_word = diag_r;
        end else if (addr_is(rd_addr_r, ADDR_ALMX)) begin
            rd_word = almx_r;
        end else if (addr_is(rd_addr_r, ADDR_CMD)) begin
            rd_word = WORD_ZERO;
        end
    end

    assign stat_read = cs_fall && addr_is(rd_addr_r, ADDR_DIAG);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_r <= WORD_ZERO;
            oe_r <= 1'b0;
        end else begin
            oe_r <= !cs_s_r[1];
            if (cs_fall) begin
                tx_r <= rd_word;
            end else if (sclk_fall && !cs_s_r[1]) begin
                tx_r <= {tx_r[14:0], 1'b0};
            end
        end
    end

    assign miso = tx_r[15];
    assign miso_oe = oe_r;

    // ========================================
    // Global command engine
    logic [15:0] cmd_req;
    logic [15:0] pend_r;
    logic [15:0] go_r;

    always_comb begin
        cmd_req = WORD_ZERO;
        if (wr_frame && addr_is(frame_addr, ADDR_CMD)) begin
            if (frame_addr[0]) begin
                cmd_req[15:8] = frame_r[7:0];
            end else begin
                cmd_req[7:0] = frame_r[7:0];
            end
        end
    end

    // Engines execute bits 0,2,3,5-9,12-15 and answer on cmd_done
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pend_r <= WORD_ZERO;
            go_r <= WORD_ZERO;
        end else begin
            go_r <= cmd_req & ~pend_r;
            pend_r <= (pend_r & ~(cmd_done | (go_r & CMD_LOCAL)))
                      | cmd_req;
        end
    end

    assign cmd_go = go_r;

    // ========================================
    // Power-down and recording
    scar_pwr_t pwr_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pwr_r <= PW_AWAKE;
        end else begin
            case (pwr_r)
                PW_AWAKE: begin
                    if (go_r[CM_PWRDN]) begin
                        pwr_r <= PW_SLEEP;
                    end
                end
                PW_SLEEP: begin
                    if (cs_fall || cs_rise || timer_wake) begin
                        pwr_r <= PW_AWAKE;
                    end
                end
                default: pwr_r <= PW_AWAKE;
            endcase
        end
    end

    assign sensor_sleep = (pwr_r == PW_SLEEP);

    logic rec_r;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rec_r <= 1'b0;
        end else if (go_r[CM_RECORD]) begin
            rec_r <= !rec_r;
        end
    end

    assign recording = rec_r;

    // ========================================
    // Diagnostic status word
    logic [15:0] diag_nxt;
    logic clr_all;
    assign clr_all = go_r[CM_CLRSTAT] || go_r[CM_SWRST];

    always_comb begin
        diag_nxt = clr_all ? WORD_ZERO : diag_r;
        if (stat_read && !cfg.autoclr_dis) begin
            diag_nxt[ST_SPEC_HI:ST_SPEC_LO] = 6'h00;
        end
        if (events.record_ok) begin
            diag_nxt[ST_ESC] = 1'b0;
        end
        if (!cfg.latch_en) begin
            diag_nxt[ST_SYS] = 1'b0;
            diag_nxt[ST_CKSUM] = 1'b0;
            diag_nxt[ST_VHI] = 1'b0;
            diag_nxt[ST_VLO] = 1'b0;
        end
        // Sets win over every clear
        diag_nxt[ST_SYS] = diag_nxt[ST_SYS] | events.sys_alarm;
        diag_nxt[ST_SPEC_HI:ST_SPEC_LO] =
            diag_nxt[ST_SPEC_HI:ST_SPEC_LO] | events.spec_alarm;
        diag_nxt[ST_DRDY] = events.data_ready;
        diag_nxt[ST_CKSUM] = diag_nxt[ST_CKSUM] | events.cksum_err;
        diag_nxt[ST_STEST] = diag_nxt[ST_STEST] | events.selftest_fail;
        diag_nxt[ST_ESC] = diag_nxt[ST_ESC] | esc_frame;
        diag_nxt[ST_SPI] = diag_nxt[ST_SPI] | frame_err_r;
        diag_nxt[ST_FLASH] = diag_nxt[ST_FLASH] | events.flash_upd_fail;
        diag_nxt[ST_VHI] = diag_nxt[ST_VHI] | events.supply_hi;
        diag_nxt[ST_VLO] = diag_nxt[ST_VLO] | events.supply_lo;
        diag_nxt[15] = 1'b0;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            diag_r <= DIAG_RESET;
        end else begin
            diag_r <= diag_nxt;
        end
    end

    // ========================================
    // X-axis alarm word
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            almx_r <= ALMX_RESET;
        end else begin
            almx_r <= {xalm.band_flags, 1'b0, xalm.crit_band};
        end
    end

    // ========================================
    // Checks
    a_frame_count_err: assert property (@(posedge core_clk) disable iff (rst)
        cs_rise && (cnt_r != CNT_ZERO) |=> ##1 diag_r[ST_SPI])
        else $error("bad clock count not flagged");

    a_escape_flag_set: assert property (@(posedge core_clk) disable iff (rst)
        esc_frame |=> diag_r[ST_ESC])
        else $error("escape frame not flagged");

    a_cmd_self_clear: assert property (@(posedge core_clk) disable iff (rst)
        go_r[CM_CLRSTAT] && !cmd_req[CM_CLRSTAT] |=> !pend_r[CM_CLRSTAT])
        else $error("status clear command stuck");

    a_cmd_read_zero: assert property (@(posedge core_clk) disable iff (rst)
        cs_fall && addr_is(rd_addr_r, ADDR_CMD) |=> tx_r == WORD_ZERO)
        else $error("command word read not zero");

    a_status_clear_once: assert property (@(posedge core_clk)
        disable iff (rst)
        go_r[CM_CLRSTAT] && !events.selftest_fail |=> !diag_r[ST_STEST])
        else $error("status clear missed");

    a_ready_follows: assert property (@(posedge core_clk) disable iff (rst)
        ##1 diag_r[ST_DRDY] == $past(events.data_ready))
        else $error("ready bit not following engine");

    a_sleep_wake_cs: assert property (@(posedge core_clk) disable iff (rst)
        sensor_sleep && cs_fall |=> !sensor_sleep)
        else $error("no wake on chip select");

    a_record_toggle: assert property (@(posedge core_clk) disable iff (rst)
        go_r[CM_RECORD] |=> recording != $past(recording))
        else $error("record did not toggle");

    a_supply_flags: assert property (@(posedge core_clk) disable iff (rst)
        events.supply_hi && events.supply_lo |=> diag_r[ST_VHI:ST_VLO] == 2'h3)
        else $error("supply flags not set");

    a_spec_read_clear: assert property (@(posedge core_clk)
        disable iff (rst)
        stat_read && !cfg.autoclr_dis && !clr_all && events.spec_alarm == 6'h00
        |=> diag_r[ST_SPEC_HI:ST_SPEC_LO] == 6'h00)
        else $error("spectral bits not cleared by read");

endmodule

`default_nettype wire

// ### pkg/scar_pkg.sv
// Constants, field positions and carriers for the status/command block.
// Assumes a 16-bit framed serial link and a same-clock alarm engine.
`default_nettype none

package scar_pkg;
    // ========================================
    // Register addresses (byte addresses)
    localparam logic [6:0] ADDR_DIAG = 7'h3C;
    localparam logic [6:0] ADDR_CMD = 7'h3E;
    localparam logic [6:0] ADDR_ALMX = 7'h40;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] DIAG_RESET = 16'h0000;
    localparam logic [15:0] ALMX_RESET = 16'h0000;
    localparam logic [15:0] ESCAPE_FRAME = 16'h00E8;

    // ========================================
    // Frame layout
    localparam int FRAME_RW = 15;
    localparam int ADDR_HI = 14;
    localparam int ADDR_LO = 8;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_LAST = 4'hF;
    localparam logic [3:0] CNT_STEP = 4'h1;

    // ========================================
    // Diagnostic status bit positions
    localparam int ST_SYS = 14;
    localparam int ST_SPEC_HI = 13;
    localparam int ST_SPEC_LO = 8;
    localparam int ST_DRDY = 7;
    localparam int ST_CKSUM = 6;
    localparam int ST_STEST = 5;
    localparam int ST_ESC = 4;
    localparam int ST_SPI = 3;
    localparam int ST_FLASH = 2;
    localparam int ST_VHI = 1;
    localparam int ST_VLO = 0;

    // ========================================
    // Global command bit positions
    localparam int CM_AUTONULL = 0;
    localparam int CM_PWRDN = 1;
    localparam int CM_STEST = 2;
    localparam int CM_FACTORY = 3;
    localparam int CM_CLRSTAT = 4;
    localparam int CM_FTEST = 5;
    localparam int CM_SAVE = 6;
    localparam int CM_SWRST = 7;
    localparam int CM_CLRREC = 8;
    localparam int CM_BANDERASE = 9;
    localparam int CM_BUFRST = 10;
    localparam int CM_RECORD = 11;
    localparam int CM_BANDSAVE = 12;
    localparam int CM_RETRIEVE = 13;
    localparam int CM_BANDLOAD = 14;
    localparam int CM_NULLCLR = 15;
    // Commands finished inside this block
    localparam logic [15:0] CMD_LOCAL = 16'h0C12;

    // ========================================
    // Carriers
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } scar_spi_in_t;

    typedef struct packed {
        logic sys_alarm;
        logic [5:0] spec_alarm;
        logic data_ready;
        logic cksum_err;
        logic selftest_fail;
        logic flash_upd_fail;
        logic supply_hi;
        logic supply_lo;
        logic record_ok;
    } scar_events_t;

    typedef struct packed {
        logic latch_en;
        logic autoclr_dis;
    } scar_cfg_t;

    typedef struct packed {
        logic [11:0] band_flags;
        logic [2:0] crit_band;
    } scar_xalm_t;

    typedef enum logic [1:0] {
        PW_AWAKE = 2'b01,
        PW_SLEEP = 2'b10
    } scar_pwr_t;
endpackage

`default_nettype wire

// ### bench/scar_host.sv
// Host model: framed serial master, mode 3, MSB first.
// Assumes the device samples sclk and cs_n with its own clock.
`default_nettype none

module scar_host (
    // Serial pins
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam time HALF = 32ns;

    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        mosi = 1'b1;
    end

    // ========================================
    // One frame of nbits clocks
    task automatic xfer(input logic [15:0] tx, input int nbits,
                        output logic [15:0] rx);
        rx = 16'h0000;
        cs_n = 1'b0;
        #(2 * HALF);
        for (int i = 0; i < nbits; i++) begin
            // Device bit stands until the falling edge
            rx = {rx[14:0], miso};
            sclk = 1'b0;
            mosi = tx[15 - i];
            #HALF;
            sclk = 1'b1;
            #HALF;
        end
        #(2 * HALF);
        cs_n = 1'b1;
        mosi = ~mosi;
        #(4 * HALF);
    endtask
endmodule

`default_nettype wire

// ### bench/scar_regs_tb.sv
// Bench for the status, command and x alarm words.
// Assumes the host model and the register block compiled before.
`default_nettype none

module scar_regs_tb
    import scar_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int LIMIT = 60000;
    logic core_clk;
    logic rst;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic oe_seen;
    scar_spi_in_t spi_in;
    scar_events_t events;
    scar_cfg_t cfg;
    scar_xalm_t xalm;
    logic timer_wake;
    logic [15:0] cmd_done;
    logic [15:0] cmd_go;
    logic sensor_sleep;
    logic recording;
    logic [15:0] go_seen;
    logic [15:0] r;
    logic slept;
    int go_cnt;
    int cycles;
    int errors;
    int checked;

    assign spi_in = {sclk, cs_n, mosi};

    scar_host scar_host_i (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(miso));
    scar_regs scar_regs_i (.core_clk(core_clk), .rst(rst),
        .spi_in(spi_in), .miso(miso), .miso_oe(miso_oe), .events(events),
        .cfg(cfg), .xalm(xalm), .timer_wake(timer_wake),
        .cmd_done(cmd_done), .cmd_go(cmd_go),
        .sensor_sleep(sensor_sleep), .recording(recording));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ========================================
    // Monitors and timeout
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        go_seen <= go_seen | cmd_go;
        go_cnt <= go_cnt + $countones(cmd_go);
        if (sensor_sleep) begin
            slept <= 1'b1;
        end
        if (miso_oe) begin
            oe_seen <= 1'b1;
        end
        if (cycles == LIMIT) begin
            errors++;
            stop_test();
        end
    end

    // ========================================
    // Tasks
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [15:0] x;
        scar_host_i.xfer({1'b1, a, d}, 16, x);
        step(1);
    endtask

    task automatic rdc(input logic [6:0] a, input logic [15:0] exp);
        logic [15:0] d;
        scar_host_i.xfer({1'b0, a, 8'h00}, 16, d);
        scar_host_i.xfer(16'h0000, 16, d);
        chk(d, exp);
        step(1);
    endtask

    task automatic done_pulse(input logic [15:0] b);
        cmd_done = b;
        step(1);
        cmd_done = 16'h0000;
        step(1);
    endtask

    task automatic stop_test();
        $display("Counts: checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ========================================
    // Main sequence
    initial begin
        rst = 1'b1;
        events = 14'h0000;
        cfg = 2'b10;
        xalm = 15'h0000;
        timer_wake = 1'b0;
        cmd_done = 16'h0000;
        go_seen = 16'h0000;
        go_cnt = 0;
        slept = 1'b0;
        oe_seen = 1'b0;
        cycles = 0;
        errors = 0;
        checked = 0;
        step(5);
        rst = 1'b0;
        step(2);
        chk({15'h0000, miso_oe}, 16'h0000);
        rdc(ADDR_DIAG, 16'h0000);
        rdc(ADDR_ALMX, 16'h0000);
        rdc(7'h50, 16'h0000);
        chk({15'h0000, oe_seen}, 16'h0001);
        chk({15'h0000, miso_oe}, 16'h0000);
        $display("Test reset done");

        events = 14'h357E;
        step(2);
        events = 14'h0040;
        rdc(ADDR_DIAG, 16'h6AE7);
        rdc(ADDR_DIAG, 16'h40E7);
        wr(ADDR_CMD, 8'h10);
        rdc(ADDR_DIAG, 16'h0080);
        events = 14'h0000;
        rdc(ADDR_DIAG, 16'h0000);
        cfg = 2'b01;
        events = 14'h0002;
        rdc(ADDR_DIAG, 16'h0001);
        events = 14'h1F80;
        step(2);
        events = 14'h0000;
        rdc(ADDR_DIAG, 16'h3F00);
        rdc(ADDR_DIAG, 16'h3F00);
        wr(ADDR_DIAG, 8'hFF);
        wr(ADDR_CMD, 8'h10);
        rdc(ADDR_DIAG, 16'h0000);
        $display("Test status done");

        scar_host_i.xfer(ESCAPE_FRAME, 16, r);
        rdc(ADDR_DIAG, 16'h0010);
        events = 14'h0001;
        step(1);
        events = 14'h0000;
        rdc(ADDR_DIAG, 16'h0000);
        scar_host_i.xfer(16'h0000, 12, r);
        rdc(ADDR_DIAG, 16'h0008);
        wr(ADDR_CMD, 8'h10);
        xalm = {12'hA5C, 3'h5};
        rdc(ADDR_ALMX, 16'hA5C5);
        $display("Test escape done");

        for (int n = 0; n < 16; n++) begin
            logic [15:0] b;
            b = 16'h0001 << n;
            go_seen = 16'h0000;
            if (n < 8) begin
                wr(ADDR_CMD, b[7:0]);
            end else begin
                wr(ADDR_CMD + 7'h01, b[15:8]);
            end
            chk(go_seen, b);
            done_pulse(b);
            rdc(ADDR_CMD, 16'h0000);
        end
        chk({15'h0000, slept}, 16'h0001);
        chk({15'h0000, sensor_sleep}, 16'h0000);
        chk({15'h0000, recording}, 16'h0001);
        wr(ADDR_CMD + 7'h01, 8'h08);
        chk({15'h0000, recording}, 16'h0000);
        go_cnt = 0;
        wr(ADDR_CMD, 8'h20);
        wr(ADDR_CMD, 8'h20);
        chk(16'(go_cnt), 16'h0001);
        done_pulse(16'h0020);
        wr(ADDR_CMD, 8'h20);
        chk(16'(go_cnt), 16'h0002);
        $display("Test commands done");
        stop_test();
    end
endmodule

`default_nettype wire
